// ### shared/pmsc_defines.svh
// Overview of operation
// - Part number registers return a fixed hardwired code; high register low nibble holds bits 11:8.
// - High part number bits 7:4 are reserved; writes change nothing.
// - Voltage monitor bit 7 is the read-only undervoltage flag, active only when detector enabled.
// - Voltage monitor bit 6 written 1 clears the undervoltage flag; reads return 0.
// - Voltage monitor bit 5 raises an interrupt request while the flag is set.
// - Voltage monitor bit 4 is write-once; with detector on, set flag forces reset.
// - Voltage monitor bit 3 keeps detection alive in stop mode when detector enabled.
// - Voltage monitor bit 2 is write-once detector enable qualifying flag, irq, reset, stop.
// - Write-once bits take only the first write after reset, later writes ignored.
// - Voltage monitor bit 0 switches the reference buffer on or off.
// - Power mode bit 7 enables regulator standby; cannot be set while deep stop select is 1.
// - Writing both standby enable and deep stop select sets only deep stop select, or neither if standby enable was already 1.
// - Standby enable clears itself when wake on interrupt is set and an interrupt occurs.
// - Power mode bit 6 reads 1 while the regulator is in standby.
// - Power mode bit 5 makes the regulator leave standby on any interrupt.
// - Power mode bit 3 reads 1 after recovery from deep stop.
// - Writing 1 to power mode bit 2 clears the deep stop recovery flag.
// - Power mode bit 1 is write-once deep stop allow; at 0 deep stop locked out.
// - Power mode bit 0 selects deep stop; cannot be set while standby enable is 1.
`ifndef PMSC_DEFINES_SVH
`define PMSC_DEFINES_SVH

`define PMSC_OFS_PART_HIGH 12'h000
`define PMSC_OFS_PART_LOW  12'h004
`define PMSC_OFS_VMON      12'h008
`define PMSC_OFS_PMODE     12'h00c

// Part code is arbitrary, chosen only to be neutral.
`define PMSC_PART_CODE     12'h5a3
`define PMSC_PART_RSVD     4'h0

`define PMSC_VM_FLAG    7
`define PMSC_VM_CLR     6
`define PMSC_VM_IRQ     5
`define PMSC_VM_RST     4
`define PMSC_VM_STOP    3
`define PMSC_VM_DET     2
`define PMSC_VM_BUF     0

`define PMSC_PM_SBY     7
`define PMSC_PM_SBYST   6
`define PMSC_PM_WAKE    5
`define PMSC_PM_DFLAG   3
`define PMSC_PM_DCLR    2
`define PMSC_PM_DALLOW  1
`define PMSC_PM_DSEL    0

`define PMSC_VM_RESET   8'h00
`define PMSC_PM_RESET   8'h00

`endif

// ### shared/pmsc_pkg.sv
package pmsc_pkg;

   typedef struct packed {
      logic undervolt_detect;    // Raw comparator output.
      logic regulator_in_standby;
      logic deep_stop_recovered; // Pulse on wake from deep stop.
      logic irq_active;          // Any active interrupt.
      logic in_stop;             // Device is in stop mode.
   } pmsc_status_t;

   typedef struct packed {
      logic undervolt_irq;
      logic undervolt_reset;
      logic detector_on;
      logic reference_buffer_enable;
      logic regulator_standby_enable;
      logic wake_regulator_on_irq;
      logic deep_stop_allow;
      logic deep_stop_select;
   } pmsc_ctl_t;

   typedef enum logic [1:0] {
      PMSC_IDLE,
      PMSC_DATA
   } pmsc_bus_st_t;

endpackage

// ### core/pmsc_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "pmsc_defines.svh"

module pmsc_top
   import pmsc_pkg::*;
(
   input  wire logic          clk_sys_i,   // Bus clock.
   input  wire logic          rstn_i,      // Sync reset, active low.
   input  wire logic          hsel_i,      // Slave select.
   input  wire logic [11:0]   haddr_i,     // Byte address.
   input  wire logic [1:0]    htrans_i,    // Transfer type.
   input  wire logic          hwrite_i,    // Write when high.
   input  wire logic [2:0]    hsize_i,     // Transfer size.
   input  wire logic [31:0]   hwdata_i,    // Write data.
   input  wire logic          hready_i,    // Bus ready.
   output logic      [31:0]   hrdata_o,    // Read data.
   output logic               hreadyout_o, // Slave ready.
   output logic               hresp_o,     // Always OKAY.
   input  wire pmsc_status_t  status_i,    // Analogue and mode status.
   output pmsc_ctl_t          ctl_o        // Control to analogue and regulator.
);

   pmsc_bus_st_t bus_st_q;
   logic [11:0]  addr_q;
   logic         wr_q;
   logic [7:0]   wd;
   logic         acc;
   logic         wr_vm;
   logic         wr_pm;
   logic         vm_flag_q;
   logic         vm_irq_q;
   logic         vm_rst_q;
   logic         vm_stop_q;
   logic         vm_det_q;
   logic         vm_buf_q;
   logic         vm_rst_lock_q;
   logic         vm_det_lock_q;
   logic         pm_sby_q;
   logic         pm_wake_q;
   logic         pm_dflag_q;
   logic         pm_dallow_q;
   logic         pm_dsel_q;
   logic         pm_dallow_lock_q;
   logic         det_live;
   logic [7:0]   rd_d;

   // Part code held as a typed constant so that its nibbles can be selected.
   localparam logic [11:0] part_code = `PMSC_PART_CODE;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      hit = (a[11:2] == ofs[11:2]);
   endfunction

   // True in the data phase of a write whose address phase selected this register.
   function automatic logic data_wr(input pmsc_bus_st_t st,
                                    input logic         w,
                                    input logic [11:0]  a,
                                    input logic [11:0]  ofs);
      data_wr = (st == PMSC_DATA) && w && hit(a, ofs);
   endfunction

   // ***************************************************************
   // Bus slave
   // ***************************************************************
   assign acc         = hsel_i && hready_i && htrans_i[1];
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;
   assign wd          = hwdata_i[7:0];
   assign wr_vm       = data_wr(bus_st_q, wr_q, addr_q, `PMSC_OFS_VMON);
   assign wr_pm       = data_wr(bus_st_q, wr_q, addr_q, `PMSC_OFS_PMODE);

   // A data phase follows every accepted address phase; back to back transfers
   // keep the machine in the data state.
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         bus_st_q <= PMSC_IDLE;
      end
      else
      begin
         case (bus_st_q)
            PMSC_IDLE:
            begin
               bus_st_q <= acc ? PMSC_DATA : PMSC_IDLE;
            end
            PMSC_DATA:
            begin
               bus_st_q <= acc ? PMSC_DATA : PMSC_IDLE;
            end
            default:
            begin
               bus_st_q <= PMSC_IDLE;
            end
         endcase
      end
   end

   // Address and direction are kept for use in the data phase.
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         addr_q <= 12'h000;
         wr_q   <= 1'b0;
      end
      else if (acc)
      begin
         addr_q <= haddr_i;
         wr_q   <= hwrite_i;
      end
   end

   // ***************************************************************
   // Voltage monitor register
   // ***************************************************************
   assign det_live = vm_det_q && (!status_i.in_stop || vm_stop_q);

   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         vm_flag_q <= 1'b0;
      end
      else if (det_live && status_i.undervolt_detect)
      begin
         vm_flag_q <= 1'b1;
      end
      else if (wr_vm && wd[`PMSC_VM_CLR])
      begin
         vm_flag_q <= 1'b0;
      end
   end

   // Interrupt, stop and buffer enables are plain read/write bits.
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         vm_irq_q <= 1'b0;
      end
      else if (wr_vm)
      begin
         vm_irq_q <= wd[`PMSC_VM_IRQ];
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         vm_stop_q <= 1'b0;
      end
      else if (wr_vm)
      begin
         vm_stop_q <= wd[`PMSC_VM_STOP];
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         vm_buf_q <= 1'b0;
      end
      else if (wr_vm)
      begin
         vm_buf_q <= wd[`PMSC_VM_BUF];
      end
   end

   // ***************************************************************
   // Write-once controls
   // ***************************************************************
   // The first write after reset locks each bit whatever value it carries, so
   // software that clears a bit by mistake cannot set it later.
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         vm_rst_q      <= 1'b0;
         vm_rst_lock_q <= 1'b0;
      end
      else if (wr_vm && !vm_rst_lock_q)
      begin
         vm_rst_q      <= wd[`PMSC_VM_RST];
         vm_rst_lock_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         vm_det_q      <= 1'b0;
         vm_det_lock_q <= 1'b0;
      end
      else if (wr_vm && !vm_det_lock_q)
      begin
         vm_det_q      <= wd[`PMSC_VM_DET];
         vm_det_lock_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         pm_dallow_q      <= 1'b0;
         pm_dallow_lock_q <= 1'b0;
      end
      else if (wr_pm && !pm_dallow_lock_q)
      begin
         pm_dallow_q      <= wd[`PMSC_PM_DALLOW];
         pm_dallow_lock_q <= 1'b1;
      end
   end

   // ***************************************************************
   // Power mode register
   // ***************************************************************
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         pm_sby_q <= 1'b0;
      end
      else if (pm_wake_q && status_i.irq_active)
      begin
         pm_sby_q <= 1'b0;
      end
      else if (wr_pm)
      begin
         // Deep stop select wins over standby, and each blocks the other.
         pm_sby_q <= wd[`PMSC_PM_SBY] && !pm_dsel_q && !wd[`PMSC_PM_DSEL];
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         pm_wake_q <= 1'b0;
      end
      else if (wr_pm)
      begin
         pm_wake_q <= wd[`PMSC_PM_WAKE];
      end
   end

   // Select is judged against the standby bit as it stands before the write,
   // so one write can never leave both bits set.
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         pm_dsel_q <= 1'b0;
      end
      else if (wr_pm)
      begin
         pm_dsel_q <= wd[`PMSC_PM_DSEL] && !pm_sby_q;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         pm_dflag_q <= 1'b0;
      end
      else if (status_i.deep_stop_recovered)
      begin
         pm_dflag_q <= 1'b1;
      end
      else if (wr_pm && wd[`PMSC_PM_DCLR])
      begin
         pm_dflag_q <= 1'b0;
      end
   end

   // ***************************************************************
   // Read data and control outputs
   // ***************************************************************
   always_comb
   begin
      rd_d = 8'h00;
      if (hit(haddr_i, `PMSC_OFS_PART_HIGH))
      begin
         // Reserved upper nibble reads as a fixed zero and ignores writes.
         rd_d = {`PMSC_PART_RSVD, part_code[11:8]};
      end
      else if (hit(haddr_i, `PMSC_OFS_PART_LOW))
      begin
         rd_d = part_code[7:0];
      end
      else if (hit(haddr_i, `PMSC_OFS_VMON))
      begin
         // Acknowledge bit 6 and reserved bit 1 read as zero.
         rd_d = {vm_flag_q, 1'b0, vm_irq_q, vm_rst_q, vm_stop_q, vm_det_q, 1'b0, vm_buf_q};
      end
      else if (hit(haddr_i, `PMSC_OFS_PMODE))
      begin
         rd_d = {pm_sby_q, status_i.regulator_in_standby, pm_wake_q, 1'b0,
                 pm_dflag_q, 1'b0, pm_dallow_q, pm_dsel_q};
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         hrdata_o <= 32'h0000_0000;
      end
      else if (acc && !hwrite_i)
      begin
         hrdata_o <= {24'h00_0000, rd_d};
      end
   end

   // Detector outputs other than the buffer enable are gated by the detector enable, so a flag left
   // over from before the detector was switched off cannot act.
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         ctl_o.undervolt_irq           <= 1'b0;
         ctl_o.undervolt_reset         <= 1'b0;
         ctl_o.detector_on             <= 1'b0;
         ctl_o.reference_buffer_enable <= 1'b0;
      end
      else
      begin
         ctl_o.undervolt_irq           <= vm_det_q && vm_irq_q && vm_flag_q;
         ctl_o.undervolt_reset         <= vm_det_q && vm_rst_q && vm_flag_q;
         ctl_o.detector_on             <= det_live;
         ctl_o.reference_buffer_enable <= vm_buf_q;
      end
   end

   // Regulator controls.
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         ctl_o.regulator_standby_enable <= 1'b0;
         ctl_o.wake_regulator_on_irq    <= 1'b0;
      end
      else
      begin
         ctl_o.regulator_standby_enable <= pm_sby_q;
         ctl_o.wake_regulator_on_irq    <= pm_wake_q;
      end
   end

   // Deep stop is only offered to the mode logic once it has been allowed.
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         ctl_o.deep_stop_allow  <= 1'b0;
         ctl_o.deep_stop_select <= 1'b0;
      end
      else
      begin
         ctl_o.deep_stop_allow  <= pm_dallow_q;
         ctl_o.deep_stop_select <= pm_dallow_q && pm_dsel_q;
      end
   end

endmodule
`default_nettype wire

// ### verif/pmsc_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "pmsc_defines.svh"
module pmsc_checker
   import pmsc_pkg::*;
(
   input wire logic          clk_sys_i,   // Bus clock.
   input wire logic          rstn_i,      // Sync reset, active low.
   input wire logic          hsel_i,      // Slave select.
   input wire logic [11:0]   haddr_i,     // Byte address.
   input wire logic [1:0]    htrans_i,    // Transfer type.
   input wire logic          hwrite_i,    // Write when high.
   input wire logic [31:0]   hwdata_i,    // Write data.
   input wire logic          hready_i,    // Bus ready.
   input wire logic [31:0]   hrdata_o,    // Read data.
   input wire pmsc_status_t  status_i,    // Analogue and mode status.
   input wire pmsc_ctl_t     ctl_o        // Control outputs.
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   wire rq = hsel_i && hready_i && htrans_i[1];
   a_irq_needs_det: assert property (ctl_o.undervolt_irq |-> ctl_o.detector_on)
      else $error("Interrupt without detector.");
   a_rst_needs_det: assert property (ctl_o.undervolt_reset |-> ctl_o.detector_on)
      else $error("Reset without detector.");
   a_sel_needs_allow: assert property (ctl_o.deep_stop_select |-> ctl_o.deep_stop_allow)
      else $error("Deep stop selected while locked out.");
   a_sby_sel_excl: assert property (!(ctl_o.deep_stop_select && ctl_o.regulator_standby_enable))
      else $error("Standby and deep stop both set.");
   a_wake_clears: assert property (ctl_o.wake_regulator_on_irq && ctl_o.regulator_standby_enable &&
      status_i.irq_active |=> ##1 !ctl_o.regulator_standby_enable)
      else $error("Standby not left on interrupt.");
   a_id_high: assert property (rq && !hwrite_i && haddr_i == `PMSC_OFS_PART_HIGH |=> hrdata_o == 32'h00000005)
      else $error("Wrong high part number.");
   a_id_low: assert property (rq && !hwrite_i && haddr_i == `PMSC_OFS_PART_LOW |=> hrdata_o == 32'h000000a3)
      else $error("Wrong low part number.");
   a_vm_ack_zero: assert property (rq && !hwrite_i && haddr_i == `PMSC_OFS_VMON |=> !hrdata_o[6] && !hrdata_o[1])
      else $error("Flag clear bit read back.");
   a_pm_ack_zero: assert property (rq && !hwrite_i && haddr_i == `PMSC_OFS_PMODE |=> !hrdata_o[2])
      else $error("Deep stop clear bit read back.");
   a_buf_follows: assert property (rq && hwrite_i && haddr_i == `PMSC_OFS_VMON |-> ##3
      ctl_o.reference_buffer_enable == $past(hwdata_i[0], 2))
      else $error("Buffer enable does not follow write.");
endmodule
bind pmsc_top pmsc_checker chk_u (.clk_sys_i, .rstn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i,
   .hready_i, .hrdata_o, .status_i, .ctl_o);
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "pmsc_defines.svh"
module tb_top
   import pmsc_pkg::*;
;
   localparam logic [11:0] ph = `PMSC_OFS_PART_HIGH;
   localparam logic [11:0] pl = `PMSC_OFS_PART_LOW;
   localparam logic [11:0] vm = `PMSC_OFS_VMON;
   localparam logic [11:0] pm = `PMSC_OFS_PMODE;
   logic         clk = 1'b0;
   logic         rstn = 1'b0;
   logic         hsel = 1'b0;
   logic         hwr = 1'b0;
   logic [11:0]  addr = 12'h000;
   logic [1:0]   trans = 2'h0;
   logic [31:0]  wdata = 32'h0;
   wire  [31:0]  rdata;
   wire          rdy;
   wire          resp;
   pmsc_status_t st = '0;
   pmsc_ctl_t    ctl;
   int           miscompares = 0;
   int           compares = 0;
   always #5 clk = ~clk;
   pmsc_top dut_u (.clk_sys_i(clk), .rstn_i(rstn), .hsel_i(hsel), .haddr_i(addr), .htrans_i(trans), .hwrite_i(hwr),
      .hsize_i(3'h2), .hwdata_i(wdata), .hready_i(rdy), .hrdata_o(rdata), .hreadyout_o(rdy), .hresp_o(resp),
      .status_i(st), .ctl_o(ctl));
   task automatic results();
      $display("Compares %0d, miscompares %0d.", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e)
      begin
         miscompares++;
         $display("FAIL %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // Single AHB transfer; entered and left just after a rising edge.
   task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      addr <= a;
      trans <= 2'h2;
      hwr <= w;
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      trans <= 2'h0;
      wdata <= d;
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      r = rdata;
      chk({31'h0, resp}, 32'h0);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(a, 1'b1, d, r);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] r;
      xfer(a, 1'b0, 32'h0, r);
      chk(r, e);
   endtask
   task automatic cc(input logic [7:0] e);
      chk({24'h0, ctl}, {24'h0, e});
   endtask
   task automatic pul(input int b);
      st[b] <= 1'b1;
      @(posedge clk);
      st[b] <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rst();
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
   endtask
   initial
   begin
      repeat (3000) @(posedge clk);
      miscompares++;
      results();
   end
   initial
   begin
      rst();
      pul(4);
      rd(vm, 32'h00);
      rd(ph, 32'h05);
      rd(pl, 32'ha3);
      rd(pm, 32'h00);
      rd(12'h010, 32'h00);
      wr(ph, 32'hff);
      rd(ph, 32'h05);
      wr(vm, 32'h2d);
      rd(vm, 32'h2d);
      cc(8'h30);
      wr(vm, 32'h14);
      rd(vm, 32'h04);
      wr(vm, 32'h21);
      pul(4);
      rd(vm, 32'ha5);
      cc(8'hb0);
      wr(vm, 32'h61);
      rd(vm, 32'h25);
      cc(8'h30);
      st.in_stop <= 1'b1;
      pul(4);
      rd(vm, 32'h25);
      wr(vm, 32'h29);
      pul(4);
      rd(vm, 32'had);
      st.in_stop <= 1'b0;
      wr(pm, 32'h83);
      rd(pm, 32'h03);
      cc(8'hb3);
      wr(pm, 32'h80);
      rd(pm, 32'h02);
      wr(pm, 32'h80);
      rd(pm, 32'h82);
      wr(pm, 32'h81);
      rd(pm, 32'h02);
      wr(pm, 32'ha0);
      rd(pm, 32'ha2);
      pul(1);
      rd(pm, 32'h22);
      st.regulator_in_standby <= 1'b1;
      pul(2);
      rd(pm, 32'h6a);
      wr(pm, 32'h26);
      rd(pm, 32'h62);
      rst();
      wr(vm, 32'h14);
      pul(4);
      rd(vm, 32'h94);
      cc(8'h60);
      wr(pm, 32'h01);
      rd(pm, 32'h41);
      cc(8'h60);
      results();
   end
endmodule
`default_nettype wire
